// ---- pkg/can_filter_pkg.sv ----
// Constants, register map and carrier types for the acceptance filter block.
// Assumes a 16-bit register port with byte-free word writes and a single core clock.
package can_filter_pkg;

  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int IDX_W = 4;

  // Register offsets on the register port.
  localparam logic [7:0] OFS_PTR_0_3 = 8'h00;
  localparam logic [7:0] OFS_PTR_4_7 = 8'h01;
  localparam logic [7:0] OFS_PTR_8_11 = 8'h02;
  localparam logic [7:0] OFS_PTR_12_15 = 8'h03;
  localparam logic [7:0] OFS_FILTER_EN = 8'h04;
  localparam logic [7:0] OFS_MSKSEL_LOW = 8'h05;
  localparam logic [7:0] OFS_MSKSEL_HIGH = 8'h06;
  localparam logic [7:0] OFS_LAST_RESULT = 8'h07;
  localparam logic [7:0] OFS_MASK_BASE = 8'h08;
  localparam logic [7:0] OFS_MASK_END = 8'h0D;
  localparam logic [7:0] OFS_PATTERN_BASE = 8'h20;
  localparam logic [7:0] OFS_PATTERN_END = 8'h3F;

  // Field positions inside a standard pattern or mask word, then pointer and mask-select field widths.
  localparam int SID_HI = 15;
  localparam int SID_LO = 5;
  localparam int TYPE_BIT = 3;
  localparam int EIDTOP_HI = 1;
  localparam int EIDTOP_LO = 0;
  localparam logic [15:0] STD_IMPL_MASK = 16'hFFEB;
  localparam int PTR_W = 4;
  localparam int MSKSEL_W = 2;
  localparam int FILTERS_PER_PTR = 4;
  localparam int FILTERS_PER_MSKSEL = 8;

  localparam logic [3:0] ROUTE_FIFO = 4'hF;
  localparam logic [1:0] MSKSEL_NONE = 2'h3;
  localparam logic [3:0] LAST_FILTER = 4'hF;

  // Reset values, plus the all-ones mask applied when no mask is selected.
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] FILTER_EN_RST = 16'hFFFF;
  localparam logic [15:0] MSKSEL_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;

  typedef struct packed {
    logic ext;
    logic [10:0] sid;
    logic [17:0] eid;
  } rx_frame_s;

  typedef struct packed {
    logic fifo;
    logic [3:0] buffer;
    logic [3:0] filter;
  } hit_s;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_READ = 2'b01,
    SCAN_EVAL = 2'b10
  } scan_e;

endpackage : can_filter_pkg

// ---- src/filter_pattern_mem.sv ----
// Pattern store: one word per filter, upper half standard pattern, lower half extended.
// Assumes the caller arbitrates the single read port; read data is registered.
module filter_pattern_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic [1:0] wr_lane_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH/2-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] store [DEPTH];

  // Contents are left unreset on purpose; patterns are undefined until software writes them.
  always_ff @(posedge clk) begin
    if (wr_lane_en[1]) begin
      store[wr_addr][WIDTH-1:WIDTH/2] <= wr_data;
    end
    if (wr_lane_en[0]) begin
      store[wr_addr][WIDTH/2-1:0] <= wr_data;
    end
    rd_data <= store[rd_addr];
  end

endmodule : filter_pattern_mem

// ---- src/can_acceptance_filter_match.sv ----
// Acceptance filter: scans sixteen filters against each received identifier.
// Assumes the protocol engine holds RX_VALID and RX_FRAME until RX_READY, all on CORE_CLK.

// What this block does
// - Pointer 1111 routes to FIFO, else buffer.
// - Pointers 15..12 packed high to low nibbles.
// - Standard pattern bits must equal frame bits.
// - Type match on: select bit picks frame type.
// - Type match off: select bit ignored.
// - Extended pattern split across two words.
// - Mask source 11 none, else mask 2/1/0.
// - Two mask-source words, two bits per filter.
// - Bits 4 and 2 read zero; patterns unreset.
// - Mask one compares bit, zero ignores it.
// - Type match off accepts either frame type.
// - Disabled filters never hit.
module can_acceptance_filter_match (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [can_filter_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [can_filter_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [can_filter_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic RX_VALID,
  input wire can_filter_pkg::rx_frame_s RX_FRAME,
  output logic RX_READY,
  output logic HIT_VALID,
  output can_filter_pkg::hit_s HIT_INFO,
  output can_filter_pkg::rx_frame_s HIT_FRAME,
  output logic REJECT_VALID
);

  logic [3:0][15:0] ptr_reg;
  logic [3:0][15:0] ptr_next;
  logic [15:0] enable_reg;
  logic [15:0] enable_next;
  logic [1:0][15:0] msksel_reg;
  logic [1:0][15:0] msksel_next;
  logic [2:0][15:0] mask_std_reg;
  logic [2:0][15:0] mask_std_next;
  logic [2:0][15:0] mask_ext_reg;
  logic [2:0][15:0] mask_ext_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rd_mem_reg;
  logic rd_mem_next;
  logic rd_half_reg;
  logic rd_half_next;
  can_filter_pkg::scan_e state_reg;
  can_filter_pkg::scan_e state_next;
  logic [3:0] idx_reg;
  logic [3:0] idx_next;
  can_filter_pkg::rx_frame_s frame_reg;
  can_filter_pkg::rx_frame_s frame_next;
  logic hit_valid_reg;
  logic hit_valid_next;
  logic reject_reg;
  logic reject_next;
  can_filter_pkg::hit_s hit_reg;
  can_filter_pkg::hit_s hit_next;
  can_filter_pkg::rx_frame_s hit_frame_reg;
  can_filter_pkg::rx_frame_s hit_frame_next;
  logic last_hit_reg;
  logic last_hit_next;

  logic pat_sel;
  logic bus_mem_rd;
  logic [1:0] mem_wr_lane;
  logic [15:0] mem_wr_data;
  logic [3:0] mem_rd_addr;
  logic [31:0] mem_rd_data;
  logic filter_hit;
  logic [1:0] cur_msksel;
  logic [3:0] cur_route;

  function automatic logic f_is_pattern(input logic [7:0] addr);
    f_is_pattern = (addr >= can_filter_pkg::OFS_PATTERN_BASE) &&
                   (addr <= can_filter_pkg::OFS_PATTERN_END);
  endfunction : f_is_pattern

  function automatic logic f_is_mask(input logic [7:0] addr);
    f_is_mask = (addr >= can_filter_pkg::OFS_MASK_BASE) &&
                (addr <= can_filter_pkg::OFS_MASK_END);
  endfunction : f_is_mask

  // Mask words alternate standard then extended, one pair per mask.
  function automatic logic [1:0] f_mask_index(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - can_filter_pkg::OFS_MASK_BASE;
    f_mask_index = rel[2:1];
  endfunction : f_mask_index

  function automatic logic [3:0] f_route(input logic [3:0][15:0] ptrs, input logic [3:0] idx);
    f_route = ptrs[idx[3:2]][idx[1:0]*can_filter_pkg::PTR_W +: can_filter_pkg::PTR_W];
  endfunction : f_route

  function automatic logic [1:0] f_msksel(input logic [1:0][15:0] sel, input logic [3:0] idx);
    f_msksel = sel[idx[3]][idx[2:0]*can_filter_pkg::MSKSEL_W +: can_filter_pkg::MSKSEL_W];
  endfunction : f_msksel

  // Compare one filter against a frame; the extended part only counts for extended frames.
  function automatic logic f_match(
    input logic [15:0] pat_std,
    input logic [15:0] pat_ext,
    input logic [15:0] m_std,
    input logic [15:0] m_ext,
    input can_filter_pkg::rx_frame_s fr
  );
    logic sid_ok;
    logic eid_ok;
    logic type_ok;
    logic [17:0] pat_eid;
    logic [17:0] m_eid;
    pat_eid = {pat_std[can_filter_pkg::EIDTOP_HI:can_filter_pkg::EIDTOP_LO], pat_ext};
    m_eid = {m_std[can_filter_pkg::EIDTOP_HI:can_filter_pkg::EIDTOP_LO], m_ext};
    sid_ok = ((pat_std[can_filter_pkg::SID_HI:can_filter_pkg::SID_LO] ^ fr.sid) &
              m_std[can_filter_pkg::SID_HI:can_filter_pkg::SID_LO]) == 11'h000;
    eid_ok = ((pat_eid ^ fr.eid) & m_eid) == 18'h00000;
    if (m_std[can_filter_pkg::TYPE_BIT]) begin
      type_ok = (pat_std[can_filter_pkg::TYPE_BIT] == fr.ext);
    end else begin
      type_ok = 1'b1;
    end
    f_match = sid_ok && type_ok && (!fr.ext || eid_ok);
  endfunction : f_match

  filter_pattern_mem #(
    .WIDTH(32),
    .DEPTH(can_filter_pkg::NUM_FILTERS),
    .AW(can_filter_pkg::IDX_W)
  ) u_pattern_mem (
    .clk(CORE_CLK),
    .wr_lane_en(mem_wr_lane),
    .wr_addr(REG_ADDR[4:1]),
    .wr_data(mem_wr_data),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  assign pat_sel = f_is_pattern(REG_ADDR);
  assign bus_mem_rd = REG_RD && pat_sel;
  // Bus reads own the memory port; the scan holds in SCAN_READ while they last, so software never stalls.
  assign mem_rd_addr = bus_mem_rd ? REG_ADDR[4:1] : idx_reg;

  always_comb begin
    mem_wr_lane = 2'b00;
    mem_wr_data = REG_WDATA;
    if (REG_WR && pat_sel) begin
      if (REG_ADDR[0]) begin
        mem_wr_lane = 2'b01;
      end else begin
        mem_wr_lane = 2'b10;
        mem_wr_data = REG_WDATA & can_filter_pkg::STD_IMPL_MASK;
      end
    end
  end

  // Register writes.
  always_comb begin
    ptr_next = ptr_reg;
    enable_next = enable_reg;
    msksel_next = msksel_reg;
    mask_std_next = mask_std_reg;
    mask_ext_next = mask_ext_reg;
    if (REG_WR) begin
      if (REG_ADDR <= can_filter_pkg::OFS_PTR_12_15) begin
        ptr_next[REG_ADDR[1:0]] = REG_WDATA;
      end else if (REG_ADDR == can_filter_pkg::OFS_FILTER_EN) begin
        enable_next = REG_WDATA;
      end else if (REG_ADDR == can_filter_pkg::OFS_MSKSEL_LOW) begin
        msksel_next[0] = REG_WDATA;
      end else if (REG_ADDR == can_filter_pkg::OFS_MSKSEL_HIGH) begin
        msksel_next[1] = REG_WDATA;
      end else if (f_is_mask(REG_ADDR)) begin
        if (REG_ADDR[0]) begin
          mask_ext_next[f_mask_index(REG_ADDR)] = REG_WDATA;
        end else begin
          mask_std_next[f_mask_index(REG_ADDR)] = REG_WDATA & can_filter_pkg::STD_IMPL_MASK;
        end
      end
    end
  end

  // Register reads; pattern words arrive from the memory in the following cycle.
  always_comb begin
    rdata_next = 16'h0000;
    rd_mem_next = 1'b0;
    rd_half_next = 1'b0;
    if (REG_RD) begin
      if (REG_ADDR <= can_filter_pkg::OFS_PTR_12_15) begin
        rdata_next = ptr_reg[REG_ADDR[1:0]];
      end else if (REG_ADDR == can_filter_pkg::OFS_FILTER_EN) begin
        rdata_next = enable_reg;
      end else if (REG_ADDR == can_filter_pkg::OFS_MSKSEL_LOW) begin
        rdata_next = msksel_reg[0];
      end else if (REG_ADDR == can_filter_pkg::OFS_MSKSEL_HIGH) begin
        rdata_next = msksel_reg[1];
      end else if (REG_ADDR == can_filter_pkg::OFS_LAST_RESULT) begin
        rdata_next = {6'h00, last_hit_reg, hit_reg};
      end else if (f_is_mask(REG_ADDR)) begin
        if (REG_ADDR[0]) begin
          rdata_next = mask_ext_reg[f_mask_index(REG_ADDR)];
        end else begin
          rdata_next = mask_std_reg[f_mask_index(REG_ADDR)];
        end
      end else if (pat_sel) begin
        rd_mem_next = 1'b1;
        rd_half_next = REG_ADDR[0];
      end
    end
  end

  assign REG_RDATA = rd_mem_reg ? (rd_half_reg ? mem_rd_data[15:0] : mem_rd_data[31:16]) :
                     rdata_reg;

  assign cur_msksel = f_msksel(msksel_reg, idx_reg);
  assign cur_route = f_route(ptr_reg, idx_reg);

  always_comb begin
    if (cur_msksel == can_filter_pkg::MSKSEL_NONE) begin
      filter_hit = f_match(mem_rd_data[31:16], mem_rd_data[15:0], can_filter_pkg::ALL_ONES,
                           can_filter_pkg::ALL_ONES, frame_reg);
    end else begin
      filter_hit = f_match(mem_rd_data[31:16], mem_rd_data[15:0], mask_std_reg[cur_msksel],
                           mask_ext_reg[cur_msksel], frame_reg);
    end
  end

  // Scan filters lowest first; the first enabled hit wins.
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    frame_next = frame_reg;
    hit_valid_next = 1'b0;
    reject_next = 1'b0;
    hit_next = hit_reg;
    hit_frame_next = hit_frame_reg;
    last_hit_next = last_hit_reg;
    case (state_reg)
      can_filter_pkg::SCAN_IDLE: begin
        if (RX_VALID) begin
          frame_next = RX_FRAME;
          idx_next = 4'h0;
          state_next = can_filter_pkg::SCAN_READ;
        end
      end
      can_filter_pkg::SCAN_READ: begin
        if (!bus_mem_rd) begin
          state_next = can_filter_pkg::SCAN_EVAL;
        end
      end
      can_filter_pkg::SCAN_EVAL: begin
        if (enable_reg[idx_reg] && filter_hit) begin
          hit_valid_next = 1'b1;
          hit_next.filter = idx_reg;
          hit_next.fifo = (cur_route == can_filter_pkg::ROUTE_FIFO);
          hit_next.buffer = cur_route;
          hit_frame_next = frame_reg;
          last_hit_next = 1'b1;
          state_next = can_filter_pkg::SCAN_IDLE;
        end else if (idx_reg == can_filter_pkg::LAST_FILTER) begin
          reject_next = 1'b1;
          last_hit_next = 1'b0;
          state_next = can_filter_pkg::SCAN_IDLE;
        end else begin
          idx_next = idx_reg + 4'h1;
          state_next = can_filter_pkg::SCAN_READ;
        end
      end
      default: begin
        state_next = can_filter_pkg::SCAN_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ptr_reg <= {4{can_filter_pkg::PTR_RST}};
      enable_reg <= can_filter_pkg::FILTER_EN_RST;
      msksel_reg <= {2{can_filter_pkg::MSKSEL_RST}};
      mask_std_reg <= {3{can_filter_pkg::MASK_RST}};
      mask_ext_reg <= {3{can_filter_pkg::MASK_RST}};
      rdata_reg <= 16'h0000;
      rd_mem_reg <= 1'b0;
      rd_half_reg <= 1'b0;
      state_reg <= can_filter_pkg::SCAN_IDLE;
      idx_reg <= 4'h0;
      frame_reg <= '0;
      hit_valid_reg <= 1'b0;
      reject_reg <= 1'b0;
      hit_reg <= '0;
      hit_frame_reg <= '0;
      last_hit_reg <= 1'b0;
    end else begin
      ptr_reg <= ptr_next;
      enable_reg <= enable_next;
      msksel_reg <= msksel_next;
      mask_std_reg <= mask_std_next;
      mask_ext_reg <= mask_ext_next;
      rdata_reg <= rdata_next;
      rd_mem_reg <= rd_mem_next;
      rd_half_reg <= rd_half_next;
      state_reg <= state_next;
      idx_reg <= idx_next;
      frame_reg <= frame_next;
      hit_valid_reg <= hit_valid_next;
      reject_reg <= reject_next;
      hit_reg <= hit_next;
      hit_frame_reg <= hit_frame_next;
      last_hit_reg <= last_hit_next;
    end
  end

  assign RX_READY = (state_reg == can_filter_pkg::SCAN_IDLE);
  assign HIT_VALID = hit_valid_reg;
  assign HIT_INFO = hit_reg;
  assign HIT_FRAME = hit_frame_reg;
  assign REJECT_VALID = reject_reg;

endmodule : can_acceptance_filter_match

// ---- bench/can_frame_source.sv ----
// Partner model of the protocol engine: offers one received identifier at a time.
// Assumes the filter takes a frame on the edge where valid and ready are both high.
module can_frame_source (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic send,
  input wire can_filter_pkg::rx_frame_s frame_in,
  input wire logic rx_ready,
  output logic rx_valid,
  output can_filter_pkg::rx_frame_s rx_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  // After a take the lines show the inverse, so a late resample by the filter is caught.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_frame <= '0;
    end else if (rx_valid && rx_ready) begin
      rx_valid <= 1'b0;
      rx_frame <= ~rx_frame;
    end else if (send && !rx_valid) begin
      rx_valid <= 1'b1;
      rx_frame <= frame_in;
    end
  end
endmodule : can_frame_source

// ---- bench/can_acceptance_filter_match_checker.sv ----
// Checker for the acceptance filter: register readback, scan timing and hit routing.
// Assumes it is bound to the top module and sees only its ports.
module can_acceptance_filter_match_checker (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [can_filter_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [can_filter_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [can_filter_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic RX_VALID,
  input wire can_filter_pkg::rx_frame_s RX_FRAME,
  input wire logic RX_READY,
  input wire logic HIT_VALID,
  input wire can_filter_pkg::hit_s HIT_INFO,
  input wire can_filter_pkg::rx_frame_s HIT_FRAME,
  input wire logic REJECT_VALID
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadows follow bus writes and frame takes, so routing is judged without looking inside.
  logic [15:0] ptr_reg;
  logic [15:0] en_reg;
  can_filter_pkg::rx_frame_s frame_reg;
  logic [3:0] nib;
  assign nib = ptr_reg[HIT_INFO.filter[1:0]*4 +: 4];
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ptr_reg <= can_filter_pkg::PTR_RST;
      en_reg <= can_filter_pkg::FILTER_EN_RST;
      frame_reg <= '0;
    end else begin
      if (REG_WR && REG_ADDR == can_filter_pkg::OFS_PTR_12_15) ptr_reg <= REG_WDATA;
      if (REG_WR && REG_ADDR == can_filter_pkg::OFS_FILTER_EN) en_reg <= REG_WDATA;
      if (RX_VALID && RX_READY) frame_reg <= RX_FRAME;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_ptr_readback: assert property (REG_RD && REG_ADDR == can_filter_pkg::OFS_PTR_12_15
    |=> REG_RDATA == ptr_reg) else $error("pointer readback wrong");
  a_std_unimpl: assert property (REG_RD && REG_ADDR >= can_filter_pkg::OFS_PATTERN_BASE
    && !REG_ADDR[0] |=> !REG_RDATA[4] && !REG_RDATA[2]) else $error("unused bits not zero");
  a_take_busy: assert property (RX_VALID && RX_READY |=> !RX_READY [*2])
    else $error("ready during scan");
  a_answer_bound: assert property (RX_VALID && RX_READY
    |-> ##[3:60] (HIT_VALID || REJECT_VALID)) else $error("no scan answer");
  a_one_answer: assert property ((HIT_VALID || REJECT_VALID)
    |-> (RX_READY && !(HIT_VALID && REJECT_VALID)) ##1 (!HIT_VALID && !REJECT_VALID))
    else $error("bad answer pulse");
  a_hit_frame: assert property (HIT_VALID |-> HIT_FRAME == frame_reg)
    else $error("hit frame differs");
  a_hit_enabled: assert property (HIT_VALID |-> en_reg[HIT_INFO.filter])
    else $error("disabled filter hit");
  a_route_fifo: assert property (HIT_VALID && HIT_INFO.filter[3:2] == 2'h3
    |-> HIT_INFO.fifo == (nib == 4'hF)) else $error("fifo route wrong");
  a_route_buffer: assert property (HIT_VALID && HIT_INFO.filter[3:2] == 2'h3
    && nib != 4'hF |-> HIT_INFO.buffer == nib) else $error("buffer route wrong");
endmodule : can_acceptance_filter_match_checker

bind can_acceptance_filter_match can_acceptance_filter_match_checker
  can_acceptance_filter_match_checker_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .RX_VALID(RX_VALID), .RX_FRAME(RX_FRAME), .RX_READY(RX_READY),
  .HIT_VALID(HIT_VALID), .HIT_INFO(HIT_INFO), .HIT_FRAME(HIT_FRAME),
  .REJECT_VALID(REJECT_VALID));

// ---- bench/can_acceptance_filter_match_test.sv ----
// Testbench for the acceptance filter: register checks, a table of filter cases, then result and reset checks.
// Assumes the package offsets and a protocol engine model on the receive side.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module can_acceptance_filter_match_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] f;
    logic [15:0] sw;
    logic [15:0] ew;
    logic [15:0] ms;
    logic [15:0] me;
    logic [1:0] sel;
    can_filter_pkg::rx_frame_s fr;
    logic hit;
  } row_s;
  localparam logic [15:0] PTRS = 16'hF7A3;
  localparam row_s ROWS [10] = '{
    '{4'hC, 16'hB460, 16'h0000, 16'hFFE0, 16'h0000, 2'h0, {1'b0, 11'h5A3, 18'h00000}, 1'b1},
    '{4'hC, 16'hB460, 16'h0000, 16'hFFE0, 16'h0000, 2'h0, {1'b0, 11'h5A2, 18'h00000}, 1'b0},
    '{4'hD, 16'hB460, 16'h0000, 16'hFFC0, 16'h0000, 2'h1, {1'b0, 11'h5A2, 18'h00000}, 1'b1},
    '{4'hE, 16'hB468, 16'h0000, 16'hFFE8, 16'h0000, 2'h2, {1'b0, 11'h5A3, 18'h00000}, 1'b0},
    '{4'hE, 16'hB468, 16'h0000, 16'hFFE8, 16'h0000, 2'h2, {1'b1, 11'h5A3, 18'h00000}, 1'b1},
    '{4'hF, 16'hB468, 16'h0000, 16'hFFE0, 16'h0000, 2'h0, {1'b0, 11'h5A3, 18'h00000}, 1'b1},
    '{4'hC, 16'hB461, 16'h1234, 16'hFFE3, 16'hFFFF, 2'h0, {1'b1, 11'h5A3, 18'h11234}, 1'b1},
    '{4'hC, 16'hB461, 16'h1234, 16'hFFE3, 16'hFFFF, 2'h0, {1'b1, 11'h5A3, 18'h11235}, 1'b0},
    '{4'hD, 16'hB460, 16'h0000, 16'hFFC0, 16'h0000, 2'h3, {1'b0, 11'h5A2, 18'h00000}, 1'b0},
    '{4'hD, 16'hB460, 16'h0000, 16'hFFC0, 16'h0000, 2'h3, {1'b0, 11'h5A3, 18'h00000}, 1'b1}};
  logic core_clk, rst_n, reg_wr, reg_rd, send, rx_valid, rx_ready, hit_valid, reject_valid;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [3:0] nib;
  can_filter_pkg::rx_frame_s src_frame, rx_frame, hit_frame;
  can_filter_pkg::hit_s hit_info;
  int mismatches, samples_checked;
  can_acceptance_filter_match can_acceptance_filter_match_inst (.CORE_CLK(core_clk),
    .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .RX_VALID(rx_valid), .RX_FRAME(rx_frame),
    .RX_READY(rx_ready), .HIT_VALID(hit_valid), .HIT_INFO(hit_info),
    .HIT_FRAME(hit_frame), .REJECT_VALID(reject_valid));
  can_frame_source can_frame_source_inst (.clk(core_clk), .rst_n(rst_n), .send(send),
    .frame_in(src_frame), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_frame(rx_frame));
  task automatic end_of_test;
    if (mismatches == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // The wait is bounded so a stuck scanner ends the run instead of hanging it.
  task automatic run(input can_filter_pkg::rx_frame_s fr);
    int i;
    @(posedge core_clk);
    send <= 1'b1;
    src_frame <= fr;
    @(posedge core_clk);
    send <= 1'b0;
    for (i = 0; i < 80; i++) begin
      @(posedge core_clk);
      #1;
      if (hit_valid === 1'b1 || reject_valid === 1'b1) break;
    end
    if (i == 80) begin
      mismatches++;
      end_of_test();
    end
  endtask : run
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    send = 1'b0;
    src_frame = '0;
    mismatches = 0;
    samples_checked = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(can_filter_pkg::OFS_PTR_12_15, rd_val);
    `CHK(rd_val, 16'h0000)
    rd(can_filter_pkg::OFS_MSKSEL_LOW, rd_val);
    `CHK(rd_val, 16'h0000)
    rd(can_filter_pkg::OFS_MSKSEL_HIGH, rd_val);
    `CHK(rd_val, 16'h0000)
    rd(can_filter_pkg::OFS_FILTER_EN, rd_val);
    `CHK(rd_val, 16'hFFFF)
    wr(can_filter_pkg::OFS_PTR_12_15, PTRS);
    rd(can_filter_pkg::OFS_PTR_12_15, rd_val);
    `CHK(rd_val, PTRS)
    wr(can_filter_pkg::OFS_MSKSEL_LOW, 16'hC6A1);
    rd(can_filter_pkg::OFS_MSKSEL_LOW, rd_val);
    `CHK(rd_val, 16'hC6A1)
    wr(can_filter_pkg::OFS_PATTERN_BASE, 16'hFFFF);
    rd(can_filter_pkg::OFS_PATTERN_BASE, rd_val);
    `CHK(rd_val, 16'hFFEB)
    for (int r = 0; r < 10; r++) begin
      wr(can_filter_pkg::OFS_FILTER_EN, 16'h0001 << ROWS[r].f);
      wr(can_filter_pkg::OFS_MSKSEL_HIGH, 16'(ROWS[r].sel) << (2 * (ROWS[r].f - 8)));
      wr(can_filter_pkg::OFS_MASK_BASE + 8'(2 * ROWS[r].sel), ROWS[r].ms);
      wr(can_filter_pkg::OFS_MASK_BASE + 8'(2 * ROWS[r].sel + 1), ROWS[r].me);
      wr(can_filter_pkg::OFS_PATTERN_BASE + 8'(2 * ROWS[r].f), ROWS[r].sw);
      wr(can_filter_pkg::OFS_PATTERN_BASE + 8'(2 * ROWS[r].f + 1), ROWS[r].ew);
      run(ROWS[r].fr);
      nib = PTRS[4 * (ROWS[r].f - 12) +: 4];
      `CHK(hit_valid, ROWS[r].hit)
      if (ROWS[r].hit) begin
        `CHK({hit_info.fifo, hit_info.filter}, {nib == 4'hF, ROWS[r].f})
        `CHK(hit_frame, ROWS[r].fr)
        if (nib != 4'hF) `CHK(hit_info.buffer, nib)
      end
    end
    // Last result word: six zero bits, the last-hit flag, then fifo, buffer and filter.
    rd(can_filter_pkg::OFS_LAST_RESULT, rd_val);
    `CHK(rd_val, 16'h02AD)
    rd(8'h0E, rd_val);
    `CHK(rd_val, 16'h0000)
    wr(can_filter_pkg::OFS_FILTER_EN, 16'h0000);
    run(ROWS[9].fr);
    `CHK(reject_valid, 1'b1)
    rd(can_filter_pkg::OFS_LAST_RESULT, rd_val);
    `CHK(rd_val, 16'h00AD)
    // A second reset restores pointers, enables and masks, but the patterns survive it.
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(can_filter_pkg::OFS_PTR_12_15, rd_val);
    `CHK(rd_val, 16'h0000)
    run(ROWS[0].fr);
    `CHK(hit_valid, 1'b1)
    `CHK(hit_info, 9'h000)
    end_of_test();
  end
endmodule : can_acceptance_filter_match_test
